// >>> rtl/afhc_ctrl.sv
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
// How it works
// - Width expansion: inputs common, outputs never tied
// - Tie first device head low, others high
// - Chain each device output to next input; chain_in_n is instead driven from depth_reg, high in depth mode
// - Composite flag asserts only when all assert
// - Watch full before writing, empty before reading
// - Toggle write strobe only while not full
// - Clear the device before any write
module afhc_ctrl
    import afhc_pkg::*;
#(
    parameter int NDEV = 1,
    parameter int DATA_W = 9
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pins driven into the buffer
    output logic [DATA_W-1:0] push_data,
    output logic push_strobe_n,
    output logic pop_strobe_n,
    output logic clear_n,
    output logic head_or_replay_n,
    output logic chain_in_n,
    // Pins sampled from the buffer
    input wire logic [DATA_W-1:0] data_out,
    input wire logic [NDEV-1:0] empty_flag_n,
    input wire logic [NDEV-1:0] full_flag_n,
    input wire logic chain_out_half_pin
);
    afhc_state_t state_reg;
    logic [7:0] cnt_reg;
    logic depth_reg, first_reg, valid_reg, blocked_reg, err_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic busy, empty_seen, full_seen, half_seen, bus_done, cmd_go, mapped;

    afhc_sync_if #(.NDEV(NDEV), .DATA_W(DATA_W)) sif ();

    assign sif.empty_raw = empty_flag_n;
    assign sif.full_raw = full_flag_n;
    assign sif.half_raw = chain_out_half_pin;
    assign sif.data_raw = data_out;

    afhc_pin_sync #(.NDEV(NDEV), .DATA_W(DATA_W)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .sif(sif.sync_side)
    );

    // ----------------------------------------
    // Flag view
    // ----------------------------------------
    // common strobes, flags apart
    assign empty_seen = &(~sif.empty_sync);
    assign full_seen = &(~sif.full_sync);
    assign half_seen = ~sif.half_sync & ~depth_reg;
    assign busy = (state_reg != ST_IDLE);

    // ----------------------------------------
    // APB slave, no wait states; pready is set from the setup phase
    // ----------------------------------------
    assign mapped = (paddr == REG_CTRL) || (paddr == REG_CMD) ||
                    (paddr == REG_STATUS) || (paddr == REG_RDATA);
    assign bus_done = psel & penable & pready;
    assign cmd_go = bus_done & pwrite & ~err_reg & (paddr == REG_CMD);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            err_reg <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel & ~penable & ~pready;
            if (psel && !penable) begin
                // Orders arriving while a strobe cycle runs are refused
                err_reg <= ~mapped | (pwrite & busy & (paddr == REG_CMD));
                pslverr <= ~mapped | (pwrite & busy & (paddr == REG_CMD));
                prdata <= 32'h0000_0000;
                if (!pwrite) begin
                    case (paddr)
                        REG_CTRL: begin
                            prdata[CTRL_DEPTH_BIT] <= depth_reg;
                            prdata[CTRL_FIRST_BIT] <= first_reg;
                        end
                        REG_STATUS: begin
                            prdata[ST_BUSY_BIT] <= busy;
                            prdata[ST_EMPTY_BIT] <= empty_seen;
                            prdata[ST_FULL_BIT] <= full_seen;
                            prdata[ST_HALF_BIT] <= half_seen;
                            prdata[ST_VALID_BIT] <= valid_reg;
                            prdata[ST_BLOCKED_BIT] <= blocked_reg;
                        end
                        REG_RDATA: prdata[DATA_W-1:0] <= rdata_reg;
                        default: prdata <= 32'h0000_0000;
                    endcase
                end
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            depth_reg <= 1'b0;
            first_reg <= 1'b0;
        end else if (bus_done && pwrite && !err_reg && paddr == REG_CTRL) begin
            depth_reg <= pwdata[CTRL_DEPTH_BIT];
            first_reg <= pwdata[CTRL_FIRST_BIT];
        end
    end

    // ----------------------------------------
    // Strobe sequencer
    // ----------------------------------------
    // clear runs from reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_CLEAR_LOW;
            cnt_reg <= CLEAR_LOW_CYC - 8'h01;
            clear_n <= 1'b0;
            push_strobe_n <= 1'b1;
            pop_strobe_n <= 1'b1;
            head_or_replay_n <= 1'b1;
            chain_in_n <= 1'b0;
            push_data <= '0;
            rdata_reg <= '0;
            valid_reg <= 1'b0;
            blocked_reg <= 1'b0;
        end else begin
            chain_in_n <= depth_reg;
            case (state_reg)
                ST_IDLE: begin
                    head_or_replay_n <= depth_reg ? ~first_reg : 1'b1;
                    if (cmd_go) begin
                        blocked_reg <= 1'b0;
                        if (pwdata[CMD_CLEAR_BIT]) begin
                            clear_n <= 1'b0;
                            cnt_reg <= CLEAR_LOW_CYC - 8'h01;
                            state_reg <= ST_CLEAR_LOW;
                        end else if (pwdata[CMD_REPLAY_BIT]) begin
                            if (depth_reg) begin
                                blocked_reg <= 1'b1;
                            end else begin
                                head_or_replay_n <= 1'b0;
                                cnt_reg <= REPLAY_LOW_CYC - 8'h01;
                                state_reg <= ST_REPLAY_LOW;
                            end
                        end else if (pwdata[CMD_PUSH_BIT]) begin
                            if (full_seen) begin
                                blocked_reg <= 1'b1;
                            end else begin
                                push_strobe_n <= 1'b0;
                                push_data <= pwdata[CMD_DATA_LSB +: DATA_W];
                                cnt_reg <= PUSH_LOW_CYC - 8'h01;
                                state_reg <= ST_PUSH_LOW;
                            end
                        end else if (pwdata[CMD_POP_BIT]) begin
                            if (empty_seen) begin
                                blocked_reg <= 1'b1;
                            end else begin
                                pop_strobe_n <= 1'b0;
                                valid_reg <= 1'b0;
                                cnt_reg <= POP_LOW_CYC - 8'h01;
                                state_reg <= ST_POP_LOW;
                            end
                        end
                    end
                end
                ST_PUSH_LOW, ST_POP_LOW, ST_CLEAR_LOW, ST_REPLAY_LOW: begin
                    if (cnt_reg == 8'h00) begin
                        if (state_reg == ST_POP_LOW) begin
                            rdata_reg <= sif.data_sync;
                            valid_reg <= 1'b1;
                        end
                        push_strobe_n <= 1'b1;
                        pop_strobe_n <= 1'b1;
                        clear_n <= 1'b1;
                        head_or_replay_n <= depth_reg ? ~first_reg : 1'b1;
                        cnt_reg <= SETTLE_CYC - 8'h01;
                        state_reg <= ST_RECOVER;
                    end else begin
                        cnt_reg <= cnt_reg - 8'h01;
                    end
                end
                ST_RECOVER: begin
                    if (cnt_reg == 8'h00) begin
                        state_reg <= ST_IDLE;
                    end else begin
                        cnt_reg <= cnt_reg - 8'h01;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence push_pulse_s;
        !push_strobe_n[*3] ##1 push_strobe_n[*8];
    endsequence
    sequence pop_pulse_s;
        !pop_strobe_n[*5] ##1 pop_strobe_n[*8];
    endsequence

    AST_PUSH_PULSE: assert property ($fell(push_strobe_n) |-> push_pulse_s)
        else $error("push strobe width or recovery wrong");
    AST_POP_PULSE: assert property ($fell(pop_strobe_n) |-> pop_pulse_s)
        else $error("pop strobe width or recovery wrong");
    AST_NO_PUSH_FULL: assert property ($fell(push_strobe_n) |-> !$past(full_seen))
        else $error("push strobed while full");
    AST_NO_POP_EMPTY: assert property ($fell(pop_strobe_n) |-> !$past(empty_seen))
        else $error("pop strobed while empty");
    AST_CLEAR_QUIET: assert property (!clear_n |-> push_strobe_n && pop_strobe_n)
        else $error("strobe active during clear");
    AST_REPLAY_SINGLE: assert property ($fell(head_or_replay_n) && !depth_reg |->
        push_strobe_n && pop_strobe_n ##1 !head_or_replay_n[*2])
        else $error("replay pulse malformed");
    AST_HEAD_STRAP: assert property (depth_reg && $past(depth_reg) && state_reg == ST_IDLE
        && $past(state_reg) == ST_IDLE |-> head_or_replay_n == ~$past(first_reg))
        else $error("head strap wrong in depth mode");
    AST_CHAIN_SINGLE: assert property (!depth_reg ##1 !depth_reg |-> !chain_in_n)
        else $error("chain input not tied low in single mode");
    AST_HALF_DEPTH: assert property (psel && !penable && !pwrite && paddr == REG_STATUS
        && depth_reg |=> !prdata[ST_HALF_BIT])
        else $error("half-full reported in depth mode");
    AST_APB_ANSWER: assert property (psel && !penable && !pready |=> pready)
        else $error("apb answer late");

endmodule : afhc_ctrl

// >>> inc/afhc_pkg.sv
package afhc_pkg;

    // ----------------------------------------
    // Clock and timing
    // ----------------------------------------
    localparam int CLK_PERIOD_PS = 5000;
    localparam int SYNC_STAGES = 2;
    localparam int PUSH_PULSE_NS = 15;
    localparam int ACCESS_DELAY_NS = 15;
    localparam int CLEAR_PULSE_NS = 15;
    localparam int REPLAY_PULSE_NS = 15;
    localparam int RECOVERY_NS = 10;
    localparam int FLAG_SETTLE_NS = 30;

    // Least time in ns to whole cycles, rounded up, never below one
    function automatic int cyc_min(input int ns);
        int c;
        c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction : cyc_min

    function automatic int max2(input int a, input int b);
        return (a > b) ? a : b;
    endfunction : max2

    localparam logic [7:0] PUSH_LOW_CYC = 8'(cyc_min(PUSH_PULSE_NS));
    // Read strobe held through access time plus the synchroniser delay
    localparam logic [7:0] POP_LOW_CYC = 8'(cyc_min(ACCESS_DELAY_NS) + SYNC_STAGES);
    localparam logic [7:0] CLEAR_LOW_CYC = 8'(cyc_min(CLEAR_PULSE_NS));
    localparam logic [7:0] REPLAY_LOW_CYC = 8'(cyc_min(REPLAY_PULSE_NS));
    // Recovery also waits until the flags have settled and crossed over
    localparam logic [7:0] SETTLE_CYC =
        8'(max2(cyc_min(RECOVERY_NS), cyc_min(FLAG_SETTLE_NS) + SYNC_STAGES));

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_CMD = 12'h004;
    localparam logic [11:0] REG_STATUS = 12'h008;
    localparam logic [11:0] REG_RDATA = 12'h00C;

    localparam int CTRL_DEPTH_BIT = 0;
    localparam int CTRL_FIRST_BIT = 1;
    localparam int CMD_PUSH_BIT = 0;
    localparam int CMD_POP_BIT = 1;
    localparam int CMD_CLEAR_BIT = 2;
    localparam int CMD_REPLAY_BIT = 3;
    localparam int CMD_DATA_LSB = 8;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_EMPTY_BIT = 1;
    localparam int ST_FULL_BIT = 2;
    localparam int ST_HALF_BIT = 3;
    localparam int ST_VALID_BIT = 4;
    localparam int ST_BLOCKED_BIT = 5;

    typedef enum logic [3:0] {
        ST_IDLE, ST_PUSH_LOW, ST_POP_LOW, ST_CLEAR_LOW, ST_REPLAY_LOW, ST_RECOVER
    } afhc_state_t;

endpackage : afhc_pkg

// >>> inc/afhc_sync_if.sv
`timescale 1ns/10ps
interface afhc_sync_if #(
    parameter int NDEV = 1,
    parameter int DATA_W = 9
);
    logic [NDEV-1:0] empty_raw;
    logic [NDEV-1:0] full_raw;
    logic half_raw;
    logic [DATA_W-1:0] data_raw;
    logic [NDEV-1:0] empty_sync;
    logic [NDEV-1:0] full_sync;
    logic half_sync;
    logic [DATA_W-1:0] data_sync;

    modport sync_side (
        input empty_raw, full_raw, half_raw, data_raw,
        output empty_sync, full_sync, half_sync, data_sync
    );
    modport user_side (
        input empty_sync, full_sync, half_sync, data_sync
    );
endinterface : afhc_sync_if

// >>> rtl/afhc_pin_sync.sv
`timescale 1ns/10ps
module afhc_pin_sync
    import afhc_pkg::*;
#(
    parameter int NDEV = 1,
    parameter int DATA_W = 9
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Pins in, synchronised copies out
    afhc_sync_if.sync_side sif
);
    localparam int W = 2 * NDEV + 1 + DATA_W;

    logic [W-1:0] meta_reg;
    logic [W-1:0] stable_reg;

    // ----------------------------------------
    // Two stages; only the second is ever read
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= '1;
            stable_reg <= '1;
        end else begin
            meta_reg <= {sif.empty_raw, sif.full_raw, sif.half_raw, sif.data_raw};
            stable_reg <= meta_reg;
        end
    end

    assign {sif.empty_sync, sif.full_sync, sif.half_sync, sif.data_sync} = stable_reg;

endmodule : afhc_pin_sync

// >>> sim/afhc_fifo_model.sv
`timescale 1ns/10ps
module afhc_fifo_model
    import afhc_pkg::*;
#(
    parameter int DEPTH = 4096
) (
    // Write side
    input wire logic [8:0] push_data,
    input wire logic push_strobe_n,
    // Read side and control
    input wire logic pop_strobe_n,
    input wire logic clear_n,
    input wire logic head_or_replay_n,
    input wire logic chain_in_n,
    // Outputs and flags
    output logic [8:0] data_out,
    output logic empty_flag_n,
    output logic full_flag_n,
    output logic chain_out_half_pin
);
    // ----------------------------------------
    // Behavioural buffer
    // ----------------------------------------
    logic [8:0] mem [DEPTH];
    logic [8:0] word_reg = 9'h000;
    logic half_reg = 1'b1;
    logic xo_reg = 1'b1;
    logic pop_on_empty = 1'b0;
    logic push_on_full = 1'b0;
    int wp = 0;
    int rp = 0;
    int cnt = 0;
    assign empty_flag_n = (cnt != 0);
    assign full_flag_n = (cnt != DEPTH);
    // half-full in single mode, chain pulse in depth mode
    assign chain_out_half_pin = chain_in_n ? xo_reg : half_reg;
    // floating bus shown as inverted word, so nothing is read by luck
    assign data_out = pop_strobe_n ? ~word_reg : word_reg;
    always @(negedge clear_n) begin
        wp = 0;
        rp = 0;
        cnt = 0;
        half_reg = 1'b1;
        pop_on_empty = 1'b0;
        push_on_full = 1'b0;
    end
    // write only while not full, wrap round
    always @(negedge push_strobe_n) begin
        if (clear_n && cnt != DEPTH) begin
            // last location pulses the chain output
            if (wp == DEPTH - 1) xo_reg = 1'b0;
            mem[wp] = push_data;
            wp = (wp + 1) % DEPTH;
            cnt++;
            if (cnt > DEPTH / 2) half_reg = 1'b0;
            // a read held on empty takes the first word only
            if (pop_on_empty && cnt == 1) begin
                word_reg = mem[rp];
                rp = (rp + 1) % DEPTH;
                cnt--;
                pop_on_empty = 1'b0;
            end
        end else if (clear_n) begin
            push_on_full = 1'b1;
        end
    end
    always @(posedge push_strobe_n) begin
        xo_reg = 1'b1;
        push_on_full = 1'b0;
    end
    always @(negedge pop_strobe_n) begin
        if (clear_n && cnt != 0) begin
            word_reg = mem[rp];
            rp = (rp + 1) % DEPTH;
            cnt--;
            // a write held on full stores once room appears
            if (push_on_full && !push_strobe_n) begin
                mem[wp] = push_data;
                wp = (wp + 1) % DEPTH;
                cnt++;
                push_on_full = 1'b0;
            end
        end else if (clear_n) begin
            pop_on_empty = 1'b1;
        end
    end
    // half-full released on read strobe rise
    always @(posedge pop_strobe_n) begin
        if (cnt <= DEPTH / 2) half_reg = 1'b1;
        pop_on_empty = 1'b0;
    end
    // replay in single mode only; valid while writes fit the depth
    always @(negedge head_or_replay_n) begin
        if (clear_n && !chain_in_n) begin
            rp = 0;
            cnt = wp;
            half_reg = !(cnt > DEPTH / 2);
        end
    end
endmodule : afhc_fifo_model

// >>> sim/test_async_fifo_flags_expansion.sv
`timescale 1ns/10ps
module test_async_fifo_flags_expansion;
    import afhc_pkg::*;
    // Small model depth keeps the fill test short
    localparam int DEPTH = 16;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr;
    logic [8:0] push_data, data_out;
    logic push_strobe_n, pop_strobe_n, clear_n, head_or_replay_n, chain_in_n;
    logic empty_flag_n, full_flag_n, chain_out_half_pin;
    int err_total = 0;
    int n_tests = 0;
    int cyc = 0;
    always #2.5 pclk = ~pclk;
    afhc_ctrl u_afhc_ctrl (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .push_data(push_data),
        .push_strobe_n(push_strobe_n), .pop_strobe_n(pop_strobe_n), .clear_n(clear_n),
        .head_or_replay_n(head_or_replay_n), .chain_in_n(chain_in_n), .data_out(data_out),
        .empty_flag_n(empty_flag_n), .full_flag_n(full_flag_n),
        .chain_out_half_pin(chain_out_half_pin));
    afhc_fifo_model #(.DEPTH(DEPTH)) u_afhc_fifo_model (.push_data(push_data),
        .push_strobe_n(push_strobe_n), .pop_strobe_n(pop_strobe_n), .clear_n(clear_n),
        .head_or_replay_n(head_or_replay_n), .chain_in_n(chain_in_n), .data_out(data_out),
        .empty_flag_n(empty_flag_n), .full_flag_n(full_flag_n),
        .chain_out_half_pin(chain_out_half_pin));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic complete_run();
        $display("counts: mismatches=%0d comparisons=%0d", err_total, n_tests);
        if (err_total == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run
    // Request held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Answer taken at the rising edge that sees pready, released there too
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) err_total++;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic st(output logic [31:0] r);
        logic e;
        apb(1'b0, REG_STATUS, 32'h0, r, e);
    endtask : st
    task automatic wait_idle();
        logic [31:0] r;
        int n;
        n = 0;
        do begin
            st(r);
            n++;
        end while (r[ST_BUSY_BIT] !== 1'b0 && n < 40);
        if (n >= 40) err_total++;
    endtask : wait_idle
    // Status flags: blocked, full, half, empty
    task automatic stchk(input logic [3:0] exp);
        logic [31:0] r;
        st(r);
        chk({r[ST_BLOCKED_BIT], r[ST_FULL_BIT], r[ST_HALF_BIT], r[ST_EMPTY_BIT]}, exp);
    endtask : stchk
    task automatic cmd(input logic [31:0] v);
        logic [31:0] r;
        logic e;
        apb(1'b1, REG_CMD, v, r, e);
        chk(e, 1'b0);
        wait_idle();
    endtask : cmd
    task automatic push(input logic [8:0] v);
        cmd((32'(v) << CMD_DATA_LSB) | 32'h1);
    endtask : push
    task automatic pop(input logic [8:0] exp);
        logic [31:0] r;
        logic e;
        cmd(32'h2);
        apb(1'b0, REG_RDATA, 32'h0, r, e);
        chk(r[8:0], exp);
    endtask : pop
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        logic [31:0] r;
        logic e;
        wait_idle();
        stchk(4'b0001);
        chk(chain_in_n, 1'b0);
        apb(1'b0, 12'h010, 32'h0, r, e);
        chk(e, 1'b1);
        $display("reset test done");
    endtask : t_reset
    task automatic t_fill_drain();
        for (int i = 1; i <= DEPTH; i++) begin
            push(9'(i * 37));
            stchk({1'b0, i == DEPTH, i > DEPTH / 2, 1'b0});
        end
        // Refused write leaves the full buffer untouched
        push(9'h1FF);
        stchk(4'b1110);
        for (int k = 1; k <= DEPTH; k++) begin
            pop(9'(k * 37));
            stchk({1'b0, 1'b0, DEPTH - k > DEPTH / 2, k == DEPTH});
        end
        cmd(32'h2);
        stchk(4'b1001);
        $display("fill and drain test done");
    endtask : t_fill_drain
    task automatic t_replay();
        // Fresh clear keeps the writes since it within the depth
        cmd(32'h4);
        push(9'h101);
        push(9'h0A5);
        push(9'h15A);
        pop(9'h101);
        cmd(32'h8);
        pop(9'h101);
        pop(9'h0A5);
        pop(9'h15A);
        push(9'h033);
        cmd(32'h4);
        stchk(4'b0001);
        $display("replay and clear test done");
    endtask : t_replay
    task automatic t_depth();
        logic [31:0] r;
        logic e;
        apb(1'b1, REG_CTRL, 32'h3, r, e);
        apb(1'b0, REG_CTRL, 32'h0, r, e);
        chk(r[1:0], 2'b11);
        chk({head_or_replay_n, chain_in_n}, 2'b01);
        cmd(32'h8);
        stchk(4'b1001);
        apb(1'b1, REG_CTRL, 32'h1, r, e);
        apb(1'b0, REG_CTRL, 32'h0, r, e);
        chk({head_or_replay_n, chain_in_n}, 2'b11);
        apb(1'b1, REG_CTRL, 32'h0, r, e);
        apb(1'b0, REG_CTRL, 32'h0, r, e);
        chk(chain_in_n, 1'b0);
        $display("depth mode test done");
    endtask : t_depth
    // ----------------------------------------
    // Main sequence and timeout
    // ----------------------------------------
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 40000) begin
            err_total++;
            complete_run();
        end
    end
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_fill_drain();
        t_replay();
        t_depth();
        complete_run();
    end
endmodule : test_async_fifo_flags_expansion
